// file: core/cat_pkg.sv
// Shared constants for the complementary auto-trip block.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package cat_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TRIP_CTRL  = 8'h00;  // trip_ctrl_reg
  localparam logic [7:0] OFF_SRC_ENABLE = 8'h04;  // trip_source_enable_reg
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h08;  // Sticky event flags
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h0c;  // Interrupt enables
  localparam logic [7:0] OFF_SRC_STATE  = 8'h10;  // Live source view

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SHUTDOWN = 0;  // Shutdown flag
  localparam int BIT_RESTART  = 1;  // Auto restart enable
  localparam int LSB_AC_LVL   = 2;  // ac_override_level low bit
  localparam int LSB_BD_LVL   = 4;  // bd_override_level low bit
  localparam int BIT_TRIP_IRQ = 0;  // trip_irq_flag in status/mask
  localparam int BIT_OVERRIDE = 8;  // Outputs overridden, in state view
  localparam int BIT_WAIT     = 9;  // Waiting for data edge

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 7;       // Pin, three timers, two comps, logic cell
  localparam int LVL_W   = 2;       // Override level field width
  localparam logic [NUM_SRC-1:0] RST_SRC_EN = 7'h00;
  localparam logic [LVL_W-1:0]   RST_LVL    = 2'h0;

  // ----------------------------------------------------------------
  // Override level codes
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_INACTIVE = 2'h0;  // Drive low
  localparam logic [LVL_W-1:0] LVL_RELEASE  = 2'h1;  // Stop driving
  localparam logic [LVL_W-1:0] LVL_LOW      = 2'h2;  // Drive low
  localparam logic [LVL_W-1:0] LVL_HIGH     = 2'h3;  // Drive high

  // ----------------------------------------------------------------
  // Trip state machine, Gray along run, trip, wait
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_RUN  = 2'h0,
    ST_TRIP = 2'h1,
    ST_WAIT = 2'h3
  } cat_state_e;

endpackage

// file: core/cat_sync.sv
// Two-flop synchroniser bank for asynchronous inputs.
// Assumes inputs may change at any time relative to mclk.
`timescale 1ns/100ps
module cat_sync
  import cat_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // State: first and second stage
  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cat_sync_s;

  cat_sync_s q_ff;   // Registered state
  cat_sync_s nxt_q;  // Next state

  // Per-bit chain; first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_comb
      begin
        nxt_q.stage1[gi] = asyncIn[gi];
        nxt_q.stage2[gi] = q_ff.stage1[gi];
      end
    end
  endgenerate

  // Register the stages; idle high (fault inputs are active low)
  always_ff @(posedge mclk)
  begin
    if (srst)
      q_ff <= '1;
    else
      q_ff <= nxt_q;
  end

  assign syncOut = q_ff.stage2;

endmodule // cat_sync

// file: core/cat_override.sv
// Output override mux for the four complementary outputs.
// Assumes level codes from cat_pkg; purely combinational.
`timescale 1ns/100ps
module cat_override
  import cat_pkg::*;
(
  // Control
  input  wire logic               overrideOn,
  input  wire logic [LVL_W-1:0]   acLevel,
  input  wire logic [LVL_W-1:0]   bdLevel,
  // Generator drive, order A, B, C, D
  input  wire logic [3:0]         genOut,
  // Pin drive, order A, B, C, D
  output logic      [3:0]         pinOut,
  output logic      [3:0]         pinOeN
);

  // One mux per pin; A and C take the ac level, B and D the bd level
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      logic [LVL_W-1:0] lvl;  // Level for this pin
      assign lvl = (gi % 2 == 0) ? acLevel : bdLevel;
      always_comb
      begin
        pinOut[gi] = genOut[gi];
        pinOeN[gi] = 1'b0;
        if (overrideOn)
        begin
          // Forced level while shut down
          pinOut[gi] = (lvl == LVL_HIGH);
          pinOeN[gi] = (lvl == LVL_RELEASE);
        end
      end
    end
  endgenerate

endmodule // cat_override

// file: core/cat_trip.sv
// Auto-shutdown and restart core of a complementary waveform generator.
// Assumes an AHB-Lite master on mclk and fault sources that are asynchronous.
`timescale 1ns/100ps
module cat_trip
  import cat_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  // Fault sources, active low
  input  wire logic                   faultPin,
  input  wire logic [2:0]             faultTimer,
  input  wire logic [1:0]             faultComp,
  input  wire logic                   faultLogic,
  // Generator side
  input  wire logic                   genData,
  input  wire logic [1:0]             genAC,
  input  wire logic [1:0]             genBD,
  // Output pins, A/C pair and B/D pair
  output logic      [1:0]             outputsAC,
  output logic      [1:0]             outputsACOeN,
  output logic      [1:0]             outputsBD,
  output logic      [1:0]             outputsBDOeN,
  // Interrupt
  output logic                        tripIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    cat_state_e         state;     // Trip state
    logic               ren;       // Auto restart enable
    logic [LVL_W-1:0]   acLvl;     // ac_override_level
    logic [LVL_W-1:0]   bdLvl;     // bd_override_level
    logic [NUM_SRC-1:0] srcEn;     // trip_source_enable bits
    logic               irqStat;   // trip_irq_flag
    logic               irqMask;   // Interrupt enable
    logic               wrPend;    // Write data phase pending
    logic [7:0]         wrAddr;    // Latched write offset
    logic [31:0]        rdData;    // Read data register
    logic               dataPrev;  // Last synced data level
  } cat_trip_s;

  cat_trip_s q_ff;   // Registered state
  cat_trip_s nxt_q;  // Next state

  logic [NUM_SRC-1:0] faultRaw;     // Raw sources, active low
  logic [NUM_SRC-1:0] faultSync;    // Synced sources, active low
  logic               dataSync;     // Synced data input
  logic               faultAct;     // Any enabled synced fault
  logic               faultRawAct;  // Any enabled raw fault
  logic               shutdownFlag; // Shutdown flag as seen
  logic               overrideOn;   // Outputs forced
  logic               dataRise;     // Data rising edge
  logic               wrCtrl;       // Write to trip_ctrl_reg
  logic               swSet;        // Software sets shutdown
  logic               swClrReq;     // Software asks to clear
  logic               addrPhase;    // Valid address phase
  logic               tripEnter;    // Entering shutdown
  logic [3:0]         pinOut;       // Mux out, A B C D
  logic [3:0]         pinOeN;       // Mux enables, A B C D

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // seven sources gathered in one vector
  assign faultRaw = {faultLogic, faultComp, faultTimer, faultPin};

  // sync faults and data before flag logic
  cat_sync #(.WIDTH(NUM_SRC + 1)) u_sync
  (
    .mclk    (mclk),
    .srst    (srst),
    .asyncIn ({genData, faultRaw}),
    .syncOut ({dataSync, faultSync})
  );

  // low is active; each gated by its enable
  assign faultAct    = |(~faultSync & q_ff.srcEn);
  // raw path feeds the override only
  assign faultRawAct = |(~faultRaw & q_ff.srcEn);

  // Data edge from the synced level
  assign dataRise = dataSync & ~q_ff.dataPrev;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addrPhase = hsel & hready & htrans[1];
  assign wrCtrl    = q_ff.wrPend & (q_ff.wrAddr == OFF_TRIP_CTRL);
  assign swSet     = wrCtrl & hwdata[BIT_SHUTDOWN];
  assign swClrReq  = wrCtrl & ~hwdata[BIT_SHUTDOWN];

  // flag high in shutdown or with a fault present
  assign shutdownFlag = (q_ff.state == ST_TRIP) | faultAct;

  // Register read mux
  function automatic logic [31:0] readWord(input logic [7:0] off);
    logic [31:0] w;
    w = 32'h0;
    unique case (off)
      OFF_TRIP_CTRL:
      begin
        w[BIT_SHUTDOWN]                 = shutdownFlag;
        w[BIT_RESTART]                  = q_ff.ren;
        w[LSB_AC_LVL +: LVL_W]          = q_ff.acLvl;
        w[LSB_BD_LVL +: LVL_W]          = q_ff.bdLvl;
      end
      OFF_SRC_ENABLE: w[NUM_SRC-1:0]    = q_ff.srcEn;
      OFF_IRQ_STAT:   w[BIT_TRIP_IRQ]   = q_ff.irqStat;
      OFF_IRQ_MASK:   w[BIT_TRIP_IRQ]   = q_ff.irqMask;
      OFF_SRC_STATE:
      begin
        w[NUM_SRC-1:0]                  = ~faultSync;
        w[BIT_OVERRIDE]                 = overrideOn;
        w[BIT_WAIT]                     = (q_ff.state == ST_WAIT);
      end
      default:        w                 = 32'h0;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus, trip machine and interrupt in one pass
  always_comb
  begin
    nxt_q          = q_ff;
    nxt_q.dataPrev = dataSync;
    nxt_q.wrPend   = 1'b0;
    tripEnter      = 1'b0;

    // Address phase: latch write target or load read data
    if (addrPhase)
    begin
      nxt_q.wrPend = hwrite;
      nxt_q.wrAddr = haddr[7:0];
      nxt_q.rdData = hwrite ? 32'h0 : readWord(haddr[7:0]);
    end

    // Data phase of a write
    if (q_ff.wrPend)
    begin
      unique case (q_ff.wrAddr)
        OFF_TRIP_CTRL:
        begin
          nxt_q.ren   = hwdata[BIT_RESTART];
          // level fields for the two pairs
          nxt_q.acLvl = hwdata[LSB_AC_LVL +: LVL_W];
          nxt_q.bdLvl = hwdata[LSB_BD_LVL +: LVL_W];
        end
        OFF_SRC_ENABLE: nxt_q.srcEn   = hwdata[NUM_SRC-1:0];
        OFF_IRQ_MASK:   nxt_q.irqMask = hwdata[BIT_TRIP_IRQ];
        default:        nxt_q.srcEn   = q_ff.srcEn;
      endcase
    end

    // Trip state machine
    unique case (q_ff.state)
      ST_RUN:
      begin
        if (swSet | faultAct)
          nxt_q.state = ST_TRIP;
      end
      ST_TRIP:
      begin
        if (swSet | faultAct)
          nxt_q.state = ST_TRIP;
        else if (q_ff.ren)
          nxt_q.state = ST_WAIT;
        // clear only honoured with no fault
        else if (swClrReq)
          nxt_q.state = ST_WAIT;
      end
      ST_WAIT:
      begin
        // New trip wins over the resume edge
        if (swSet | faultAct)
          nxt_q.state = ST_TRIP;
        else if (dataRise)
          nxt_q.state = ST_RUN;
      end
      default: nxt_q.state = ST_TRIP;
    endcase

    // every entry into shutdown sets the flag
    tripEnter = (q_ff.state != ST_TRIP) & (nxt_q.state == ST_TRIP);

    // Write one to clear; a new event wins over the clear
    if (q_ff.wrPend && (q_ff.wrAddr == OFF_IRQ_STAT) && hwdata[BIT_TRIP_IRQ])
      nxt_q.irqStat = 1'b0;
    if (tripEnter)
      nxt_q.irqStat = 1'b1;
  end

  // Register all state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      q_ff.state    <= ST_RUN;
      q_ff.ren      <= 1'b0;
      q_ff.acLvl    <= RST_LVL;
      q_ff.bdLvl    <= RST_LVL;
      q_ff.srcEn    <= RST_SRC_EN;
      q_ff.irqStat  <= 1'b0;
      q_ff.irqMask  <= 1'b0;
      q_ff.wrPend   <= 1'b0;
      q_ff.wrAddr   <= 8'h00;
      q_ff.rdData   <= 32'h0;
      q_ff.dataPrev <= 1'b1;  // Matches synchroniser idle, no false edge
    end
    else
      q_ff <= nxt_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // raw fault forces outputs in the same cycle
  assign overrideOn = (q_ff.state != ST_RUN) | faultRawAct;

  cat_override u_override
  (
    .overrideOn (overrideOn),
    .acLevel    (q_ff.acLvl),
    .bdLevel    (q_ff.bdLvl),
    .genOut     ({genBD[1], genAC[1], genBD[0], genAC[0]}),
    .pinOut     (pinOut),
    .pinOeN     (pinOeN)
  );

  assign outputsAC    = {pinOut[2], pinOut[0]};
  assign outputsBD    = {pinOut[3], pinOut[1]};
  assign outputsACOeN = {pinOeN[2], pinOeN[0]};
  assign outputsBDOeN = {pinOeN[3], pinOeN[1]};

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q_ff.rdData;
  assign tripIrq   = q_ff.irqStat & q_ff.irqMask;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Flag falls then edge awaited
  sequence seq_released;
    (q_ff.state == ST_TRIP) ##1 (q_ff.state == ST_WAIT);
  endsequence

  chk_sw_set_trip: assert property (swSet |=> (q_ff.state == ST_TRIP) && overrideOn)
    else $error("software set did not trip");
  chk_hold_no_ren: assert property ((q_ff.state == ST_TRIP) && !q_ff.ren && !swClrReq
    |=> (q_ff.state == ST_TRIP))
    else $error("shutdown released without restart or clear");
  chk_auto_clear: assert property ((q_ff.state == ST_TRIP) && q_ff.ren && !faultAct && !swSet
    |=> (q_ff.state == ST_WAIT))
    else $error("auto restart did not clear flag");
  chk_raw_override: assert property (faultRawAct |-> overrideOn
    && (pinOut[0] == (q_ff.acLvl == LVL_HIGH)) && (pinOut[1] == (q_ff.bdLvl == LVL_HIGH)))
    else $error("fault did not override outputs at once");
  chk_level_hold: assert property (faultAct [*2] |-> (q_ff.state == ST_TRIP) && shutdownFlag)
    else $error("persisting fault left shutdown");
  chk_irq_on_trip: assert property (tripEnter |=> q_ff.irqStat && (tripIrq == q_ff.irqMask))
    else $error("shutdown entry did not raise interrupt");
  chk_sw_clr_block: assert property (swClrReq && faultAct |=> (q_ff.state == ST_TRIP))
    else $error("software clear accepted during fault");
  chk_resume_edge: assert property (seq_released ##0 !dataRise && !faultAct && !swSet
    |=> (q_ff.state == ST_WAIT) && overrideOn)
    else $error("resumed before data edge");
  chk_edge_resume: assert property ((q_ff.state == ST_WAIT) && dataRise && !faultAct && !swSet
    |=> (q_ff.state == ST_RUN) && (faultRawAct || (pinOeN == 4'h0)))
    else $error("data edge did not resume");

  // Any state into shutdown, one edge apart
  sequence seq_trip_entry;
    (q_ff.state != ST_TRIP) ##1 (q_ff.state == ST_TRIP);
  endsequence

  // entry leaves the interrupt flag set
  chk_entry_irq: assert property (seq_trip_entry |-> q_ff.irqStat)
    else $error("shutdown entry left interrupt flag clear");
  // flag is sticky until written one
  chk_irq_sticky: assert property (q_ff.irqStat
    && !(q_ff.wrPend && (q_ff.wrAddr == OFF_IRQ_STAT) && hwdata[BIT_TRIP_IRQ]) |=> q_ff.irqStat)
    else $error("interrupt flag dropped without clear");
  // no resume without a data edge
  chk_run_needs_edge: assert property ((q_ff.state != ST_RUN) && !dataRise |=> (q_ff.state != ST_RUN))
    else $error("left shutdown without data edge");
  // a live source keeps or forces shutdown
  chk_src_hold: assert property ((q_ff.state != ST_RUN) && faultAct |=> (q_ff.state == ST_TRIP))
    else $error("restart with a source still active");
  // software set shows on the flag
  chk_flag_set: assert property (swSet |=> shutdownFlag)
    else $error("shutdown flag not set by software");
  // software clear honoured with no source
  chk_sw_clr_ok: assert property ((q_ff.state == ST_TRIP) && swClrReq && !faultAct
    |=> (q_ff.state == ST_WAIT))
    else $error("software clear ignored with no source");
  // release code lets go of each pin
  chk_release_oe: assert property (overrideOn |->
    (pinOeN[0] == (q_ff.acLvl == LVL_RELEASE)) && (pinOeN[2] == (q_ff.acLvl == LVL_RELEASE))
    && (pinOeN[1] == (q_ff.bdLvl == LVL_RELEASE)) && (pinOeN[3] == (q_ff.bdLvl == LVL_RELEASE)))
    else $error("override enable does not follow level code");
  chk_pass_through: assert property (!overrideOn |-> (pinOeN == 4'h0)
    && (pinOut == {genBD[1], genAC[1], genBD[0], genAC[0]}))
    else $error("outputs not following generator");

endmodule // cat_trip

// file: dv/cat_fault_model.sv
// Far-side model: fault sources and the generator data line.
// Assumes bench requests change just after rising edges of mclk.
`timescale 1ns/100ps
module cat_fault_model
(
  // Clock
  input  wire logic       mclk,
  // Bench requests, high asks for fault or data high
  input  wire logic [6:0] faultReq,
  input  wire logic       dataReq,
  // Fault lines, low while faulting
  output logic            faultPin,
  output logic [2:0]      faultTimer,
  output logic [1:0]      faultComp,
  output logic            faultLogic,
  // Generator data line
  output logic            genData
);
  // ----------------------------------------------------------------
  // Line drive
  // ----------------------------------------------------------------
  // Idle lines show no fault from time zero
  initial
  begin
    {faultLogic, faultComp, faultTimer, faultPin} = 7'h7f;
    genData = 1'b0;
  end

  always @(posedge mclk)
  begin
    {faultLogic, faultComp, faultTimer, faultPin} <= #1.3 ~faultReq;
    genData <= #1.7 dataReq;
  end
endmodule // cat_fault_model

// file: dv/cat_trip_test.sv
// Self-checking bench for the auto-trip block.
// Assumes cat_pkg map and a zero wait AHB-Lite slave.
`timescale 1ns/100ps
module cat_trip_test;
  import cat_pkg::*;
  // Case row: source, AC and BD levels, expected pins
  typedef struct packed
  {
    logic [2:0] src;
    logic [1:0] ac;
    logic [1:0] bd;
    logic [7:0] pins;
  } cat_row_s;
  localparam cat_row_s ROWS [7] = '{'{3'h0, 2'h0, 2'h3, 8'h0c}, '{3'h1, 2'h1, 2'h2, 8'h30},
    '{3'h2, 2'h2, 2'h1, 8'h03}, '{3'h3, 2'h3, 2'h0, 8'hc0}, '{3'h4, 2'h0, 2'h1, 8'h03},
    '{3'h5, 2'h3, 2'h3, 8'hcc}, '{3'h6, 2'h1, 2'h1, 8'h33}};
  localparam logic [7:0] OFFS [6] = '{OFF_TRIP_CTRL, OFF_SRC_ENABLE, OFF_IRQ_STAT,
    OFF_IRQ_MASK, OFF_SRC_STATE, 8'h20};
  localparam logic [7:0] RUN_PINS = 8'h84;  // genAC=10, genBD=01
  // Bench drive
  logic        mclk     = 1'b0;
  logic        srst     = 1'b1;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic [1:0]  genAC    = 2'h2;
  logic [1:0]  genBD    = 2'h1;
  logic [6:0]  faultReq = 7'h0;
  logic        dataReq  = 1'b0;
  // Design and model outputs
  wire logic        hready;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  wire logic        faultPin;
  wire logic [2:0]  faultTimer;
  wire logic [1:0]  faultComp;
  wire logic        faultLogic;
  wire logic        genData;
  wire logic [1:0]  outputsAC;
  wire logic [1:0]  outputsACOeN;
  wire logic [1:0]  outputsBD;
  wire logic [1:0]  outputsBDOeN;
  wire logic        tripIrq;
  wire logic [7:0]  pins = {outputsAC, outputsACOeN, outputsBD, outputsBDOeN};
  // Score
  int          mismatches = 0;
  int          checksDone = 0;
  logic [31:0] rdData;

  cat_trip i_cat_trip (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .faultPin(faultPin), .faultTimer(faultTimer),
    .faultComp(faultComp), .faultLogic(faultLogic), .genData(genData), .genAC(genAC),
    .genBD(genBD), .outputsAC(outputsAC), .outputsACOeN(outputsACOeN), .outputsBD(outputsBD),
    .outputsBDOeN(outputsBDOeN), .tripIrq(tripIrq));
  cat_fault_model i_cat_fault_model (.mclk(mclk), .faultReq(faultReq), .dataReq(dataReq),
    .faultPin(faultPin), .faultTimer(faultTimer), .faultComp(faultComp),
    .faultLogic(faultLogic), .genData(genData));

  // Clock and hang guard
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Register value compare
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: reg %h expected %h", $time, got, exp);
    end
  endtask
  // Pin level compare
  task automatic chkPin(input logic [7:0] exp);
    checksDone++;
    if (pins !== exp)
    begin
      mismatches++;
      $display("Error at %0t: pins %h expected %h", $time, pins, exp);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic waitRdy();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rdData = hrdata;
  endtask
  // Edges then settle
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1.6;
  endtask
  // Bounded wait for given pin levels
  task automatic waitPins(input logic [7:0] exp);
    int n;
    n = 0;
    while (pins !== exp && n < 16)
    begin
      step(1);
      n++;
    end
    if (pins !== exp)
    begin
      mismatches++;
      conclude();
    end
    chkPin(exp);
  endtask
  // Data rise, then back to normal drive
  task automatic resume();
    dataReq <= 1'b1;
    waitPins(RUN_PINS);
    dataReq <= 1'b0;
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    step(3);
  endtask
  // Fault trip and software restart for one row
  task automatic tripRow(input cat_row_s r);
    xfer(1'b1, OFF_SRC_ENABLE, 32'h1 << r.src);
    xfer(1'b1, OFF_TRIP_CTRL, {26'h0, r.bd, r.ac, 2'h0});
    faultReq <= 7'h1 << r.src;
    step(1);
    chkPin(r.pins);
    step(3);
    xfer(1'b0, OFF_SRC_STATE, 32'h0);
    chkReg(rdData & 32'h7f, 32'h1 << r.src);
    chkReg({31'h0, tripIrq}, 32'h1);
    xfer(1'b1, OFF_TRIP_CTRL, {26'h0, r.bd, r.ac, 2'h0});
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData & 32'h1, 32'h1);
    faultReq <= 7'h0;
    step(5);
    chkPin(r.pins);
    xfer(1'b1, OFF_TRIP_CTRL, {26'h0, r.bd, r.ac, 2'h0});
    xfer(1'b0, OFF_SRC_STATE, 32'h0);
    chkReg(rdData & 32'h200, 32'h200);
    chkPin(r.pins);
    resume();
    chkReg({31'h0, tripIrq}, 32'h0);
    $display("test source %0d done", r.src);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    xfer(1'b1, OFF_SRC_STATE, 32'h3ff);
    foreach (OFFS[i])
    begin
      xfer(1'b0, OFFS[i], 32'h0);
      chkReg(rdData, 32'h0);
    end
    chkPin(RUN_PINS);
    chkReg({31'h0, hresp}, 32'h0);
    $display("test reset done");
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    foreach (ROWS[i])
      tripRow(ROWS[i]);
    // Software shutdown, no auto restart
    xfer(1'b1, OFF_TRIP_CTRL, 32'h3d);
    step(1);
    chkPin(8'hcc);
    step(20);
    chkPin(8'hcc);
    chkReg({31'h0, tripIrq}, 32'h1);
    xfer(1'b1, OFF_TRIP_CTRL, 32'h3c);
    step(4);
    chkPin(8'hcc);
    resume();
    $display("test soft hold done");
    // Software shutdown with auto restart
    xfer(1'b1, OFF_TRIP_CTRL, 32'h3f);
    step(4);
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData & 32'h1, 32'h0);
    chkPin(8'hcc);
    resume();
    $display("test soft auto done");
    // Fault with auto restart
    xfer(1'b1, OFF_SRC_ENABLE, 32'h1);
    xfer(1'b1, OFF_TRIP_CTRL, 32'h32);
    faultReq <= 7'h01;
    step(1);
    chkPin(8'h0c);
    step(8);
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData & 32'h1, 32'h1);
    faultReq <= 7'h00;
    step(6);
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData & 32'h1, 32'h0);
    chkPin(8'h0c);
    resume();
    $display("test fault auto done");
    // Disabled source, then disabling a live one
    xfer(1'b1, OFF_TRIP_CTRL, 32'h30);
    faultReq <= 7'h02;
    step(5);
    chkPin(RUN_PINS);
    faultReq <= 7'h03;
    step(5);
    chkPin(8'h0c);
    xfer(1'b1, OFF_SRC_ENABLE, 32'h0);
    xfer(1'b1, OFF_TRIP_CTRL, 32'h30);
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData & 32'h1, 32'h0);
    resume();
    faultReq <= 7'h00;
    $display("test disable done");
    // Masked interrupt, unmask, clear
    xfer(1'b1, OFF_IRQ_MASK, 32'h0);
    xfer(1'b1, OFF_TRIP_CTRL, 32'h31);
    step(2);
    chkReg({31'h0, tripIrq}, 32'h0);
    xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    chkReg(rdData & 32'h1, 32'h1);
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    step(1);
    chkReg({31'h0, tripIrq}, 32'h1);
    xfer(1'b1, OFF_TRIP_CTRL, 32'h30);
    resume();
    chkReg({31'h0, tripIrq}, 32'h0);
    $display("test irq done");
    // Reset in mid-run drops a live shutdown
    xfer(1'b1, OFF_TRIP_CTRL, 32'h31);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    step(1);
    chkPin(RUN_PINS);
    chkReg({31'h0, tripIrq}, 32'h0);
    xfer(1'b0, OFF_TRIP_CTRL, 32'h0);
    chkReg(rdData, 32'h0);
    $display("test mid reset done");
    conclude();
  end
endmodule // cat_trip_test
